// ==== rtl/ebc_pkg.sv ====
// package of constants and carrier types for the emulation break controller
package ebc_pkg;

    // ********************************************************************
    // register map (apb byte addresses)
    // ********************************************************************
    localparam logic [7:0] EBC_CTRL_ADR = 8'h00;
    localparam logic [7:0] EBC_COND_ADR = 8'h04;
    localparam logic [7:0] EBC_PASS_ADR = 8'h08;
    localparam logic [7:0] EBC_RAM_ADR = 8'h0C;
    localparam logic [7:0] EBC_BA_ADR = 8'h10;
    localparam logic [7:0] EBC_STAT_ADR = 8'h14;
    localparam logic [7:0] EBC_BPC_ADR = 8'h18;
    localparam logic [7:0] EBC_TP_ADR = 8'h1C;
    localparam logic [7:0] EBC_LIST_ADR = 8'h40;

    // ********************************************************************
    // sizes, fields and reset values
    // ********************************************************************
    localparam int EBC_NLIST = 20;
    localparam logic [11:0] EBC_TOP_SMALL = 12'h7DF;
    localparam logic [11:0] EBC_TOP_LARGE = 12'hFDF;
    localparam logic [1:0] EBC_DUTY_RST = 2'h0;
    localparam int EBC_CTRL_GO = 0;
    localparam int EBC_CTRL_ADRV = 1;
    localparam int EBC_CTRL_ABORT = 2;
    localparam int EBC_CTRL_LARGE = 3;
    localparam int EBC_COND_BP = 0;
    localparam int EBC_COND_TP = 1;
    localparam int EBC_COND_CC = 2;
    localparam int EBC_COND_LIST = 3;
    localparam int EBC_COND_PASS = 4;
    localparam int EBC_COND_RAM = 5;
    localparam int EBC_COND_BA = 6;
    localparam int EBC_COND_RAM4 = 7;
    localparam int EBC_COND_BA4 = 8;

    typedef enum logic [3:0] {
        EBC_SRC_NONE, EBC_SRC_ABORT, EBC_SRC_LIST, EBC_SRC_PASS, EBC_SRC_RAM,
        EBC_SRC_BA, EBC_SRC_BP, EBC_SRC_TP, EBC_SRC_CC, EBC_SRC_RANGE
    } ebc_src_type;

    // one retired instruction as reported by the core
    typedef struct packed {
        logic valid;
        logic skipped;
        logic skip_busy;
        logic irq_xfer;
        logic halt_mode;
        logic bp_bit;
        logic [11:0] pc;
        logic [11:0] next_pc;
        logic wr8;
        logic ram_wr;
        logic [10:0] ram_adr;
        logic [7:0] ram_dat;
        logic ba_wr;
        logic [7:0] ba_dat;
        logic tp_ovf;
        logic cc_ovf;
        logic [1:0] duty;
    } ebc_exec_type;

endpackage

// ==== rtl/ebc_break_ctrl.sv ====
// break-condition logic of the in-circuit emulator, with apb register access
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// - run with start address clears executed bits and trace pointer first
// - run without start address continues from current pc, state kept
// - halt after executing an instruction at any of twenty listed addresses
// - pass-count break after programmed 1..65535 executions at one address
// - address and breakpoint matches fire only on instruction first byte
// - count writes of 4 or 8-bit value to watch address, halt at count
// - only writes to the selected watch address advance the count
// - 8-bit value counts 8-bit writes; FH upper nibble adds 4-bit low writes
// - 4-bit value at odd watch address ignores 8-bit instruction writes
// - count writes of programmed value to BA pair, halt at count
// - 8-bit BA match needs 8-bit writes; 4-bit compares A only
// - enabled breakpoint bit, trace overflow, cycle overflow halt execution
// - halt when execution address passes top of code memory for mode
// - operator abort stops execution, ignored while core in halt mode
// - stop after breaking instruction; capture break pc, next pc, tp
// - break during skip held pending and taken when skip ends
// - skipped address or breakpoint instruction records no pending break
// - break during interrupt transfer taken after transfer completes
// - time base frozen from break until resume
// - resume leaves skip-if-carry add skip function enabled
// - warn after break when display duty differs from mask duty
module ebc_break_ctrl (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire ebc_pkg::ebc_exec_type exec_i,
    input wire logic [11:0] trace_ptr_i,
    output logic run_o,
    output logic clr_exec_o,
    output logic [11:0] start_pc_o,
    output logic load_pc_o,
    output logic tbc_hold_o,
    output logic ais_skip_en_o,
    output logic duty_warn_o
);
    import ebc_pkg::*;

    // ********************************************************************
    // state and registers
    // ********************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_RUN} ebc_state_type;
    ebc_state_type state_q;
    logic [3:0] ctrl_q;
    logic [8:0] cond_q;
    logic [11:0] pass_adr_q;
    logic [15:0] pass_cnt_q, pass_tgt_q;
    logic [10:0] ram_adr_q;
    logic [7:0] ram_val_q, ba_val_q;
    logic [15:0] ram_cnt_q, ram_tgt_q, ba_cnt_q, ba_tgt_q;
    logic [11:0] list_q [EBC_NLIST];
    logic [EBC_NLIST-1:0] list_en_q;
    logic pend_q;
    ebc_src_type pend_src_q, src_q;
    logic [11:0] bpc_q, npc_q, btp_q;
    logic [1:0] mask_duty_q;
    logic [1:0] duty_q;

    function automatic logic cnt_hit(input logic [15:0] cnt, input logic [15:0] tgt);
        cnt_hit = (tgt != 16'h0000) && (cnt + 16'h0001 == tgt);
    endfunction

    // ********************************************************************
    // apb slave, single cycle answer
    // ********************************************************************
    logic acc, wr, go_req;
    logic [4:0] lidx;
    assign acc = psel_i && penable_i && ce_i;
    assign wr = acc && pwrite_i;
    assign lidx = 5'(paddr_i[6:2] - 5'h10);
    assign go_req = wr && paddr_i == EBC_CTRL_ADR && pwdata_i[EBC_CTRL_GO];

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= 4'h0;
            cond_q <= 9'h000;
            pass_adr_q <= 12'h000;
            pass_tgt_q <= 16'h0000;
            ram_adr_q <= 11'h000;
            ram_val_q <= 8'h00;
            ram_tgt_q <= 16'h0000;
            ba_val_q <= 8'h00;
            ba_tgt_q <= 16'h0000;
            list_en_q <= '0;
            mask_duty_q <= EBC_DUTY_RST;
            for (int i = 0; i < EBC_NLIST; i++) begin
                list_q[i] <= 12'h000;
            end
        end else if (wr) begin
            case (paddr_i)
                EBC_CTRL_ADR: begin
                    ctrl_q <= pwdata_i[3:0];
                    mask_duty_q <= pwdata_i[9:8];
                end
                EBC_COND_ADR: cond_q <= pwdata_i[8:0];
                EBC_PASS_ADR: begin
                    pass_adr_q <= pwdata_i[27:16];
                    pass_tgt_q <= pwdata_i[15:0];
                end
                EBC_RAM_ADR: begin
                    ram_adr_q <= pwdata_i[26:16];
                    ram_val_q <= pwdata_i[7:0];
                end
                EBC_BA_ADR: begin
                    ba_val_q <= pwdata_i[7:0];
                    ba_tgt_q <= pwdata_i[31:16];
                end
                EBC_STAT_ADR: ram_tgt_q <= pwdata_i[15:0];
                default: begin
                    if (paddr_i >= EBC_LIST_ADR && lidx < 5'(EBC_NLIST)) begin
                        list_q[lidx] <= pwdata_i[11:0];
                        list_en_q[lidx] <= pwdata_i[31];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            if (psel_i && !penable_i && !pwrite_i) begin
                case (paddr_i)
                    EBC_CTRL_ADR: prdata_o <= {22'h0, mask_duty_q, 4'h0, ctrl_q};
                    EBC_COND_ADR: prdata_o <= {23'h0, cond_q};
                    EBC_PASS_ADR: prdata_o <= {pass_cnt_q, 4'h0, pass_adr_q};
                    EBC_RAM_ADR: prdata_o <= {ram_cnt_q, 5'h0, ram_adr_q};
                    EBC_BA_ADR: prdata_o <= {ba_cnt_q, 8'h0, ba_val_q};
                    EBC_STAT_ADR: prdata_o <= {10'h0, duty_warn_o, run_o, src_q, ram_tgt_q};
                    EBC_BPC_ADR: prdata_o <= {4'h0, npc_q, 4'h0, bpc_q};
                    EBC_TP_ADR: prdata_o <= {20'h0, btp_q};
                    default: begin
                        if (paddr_i >= EBC_LIST_ADR && lidx < 5'(EBC_NLIST)) begin
                            prdata_o <= {list_en_q[lidx], 19'h0, list_q[lidx]};
                        end else begin
                            pslverr_o <= 1'b1;
                        end
                    end
                endcase
            end else if (psel_i && !penable_i && pwrite_i) begin
                pslverr_o <= !(paddr_i <= EBC_TP_ADR && paddr_i[1:0] == 2'h0
                    || paddr_i >= EBC_LIST_ADR && lidx < 5'(EBC_NLIST));
            end
        end
    end

    // ********************************************************************
    // break source evaluation for one retired instruction
    // ********************************************************************
    ebc_exec_type ex;
    logic first_ok, list_hit, pass_match, ram_match, ba_match;
    logic [11:0] top;
    ebc_src_type hit_src;
    assign ex = exec_i;
    assign first_ok = ex.valid && !ex.skipped;
    assign top = ctrl_q[EBC_CTRL_LARGE] ? EBC_TOP_LARGE : EBC_TOP_SMALL;

    always_comb begin
        list_hit = 1'b0;
        for (int i = 0; i < EBC_NLIST; i++) begin
            if (list_en_q[i] && list_q[i] == ex.pc) begin
                list_hit = 1'b1;
            end
        end
    end

    assign pass_match = cond_q[EBC_COND_PASS] && first_ok && ex.pc == pass_adr_q;
    always_comb begin
        ram_match = 1'b0;
        if (cond_q[EBC_COND_RAM] && ex.valid && ex.ram_wr && ex.ram_adr == ram_adr_q) begin
            if (!cond_q[EBC_COND_RAM4]) begin
                if (ex.wr8) begin
                    ram_match = ex.ram_dat == ram_val_q;
                end else begin
                    ram_match = ram_val_q[7:4] == 4'hF && ex.ram_dat[3:0] == ram_val_q[3:0];
                end
            end else begin
                ram_match = ex.ram_dat[3:0] == ram_val_q[3:0] && !(ex.wr8 && ram_adr_q[0]);
            end
        end
        ba_match = 1'b0;
        if (cond_q[EBC_COND_BA] && ex.valid && ex.ba_wr) begin
            if (cond_q[EBC_COND_BA4]) begin
                ba_match = ex.ba_dat[3:0] == ba_val_q[3:0];
            end else begin
                ba_match = ex.wr8 && ex.ba_dat == ba_val_q;
            end
        end
    end

    // priority: first listed source wins when several fire together
    always_comb begin
        hit_src = EBC_SRC_NONE;
        if (ctrl_q[EBC_CTRL_ABORT] && !ex.halt_mode) begin
            hit_src = EBC_SRC_ABORT;
        end else if (ex.valid && ex.pc > top) begin
            hit_src = EBC_SRC_RANGE;
        end else if (cond_q[EBC_COND_LIST] && first_ok && list_hit) begin
            hit_src = EBC_SRC_LIST;
        end else if (pass_match && cnt_hit(pass_cnt_q, pass_tgt_q)) begin
            hit_src = EBC_SRC_PASS;
        end else if (ram_match && cnt_hit(ram_cnt_q, ram_tgt_q)) begin
            hit_src = EBC_SRC_RAM;
        end else if (ba_match && cnt_hit(ba_cnt_q, ba_tgt_q)) begin
            hit_src = EBC_SRC_BA;
        end else if (cond_q[EBC_COND_BP] && first_ok && ex.bp_bit) begin
            hit_src = EBC_SRC_BP;
        end else if (cond_q[EBC_COND_TP] && ex.tp_ovf) begin
            hit_src = EBC_SRC_TP;
        end else if (cond_q[EBC_COND_CC] && ex.cc_ovf) begin
            hit_src = EBC_SRC_CC;
        end
    end

    // ********************************************************************
    // pass counters, cleared on every run start
    // ********************************************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pass_cnt_q <= 16'h0000;
            ram_cnt_q <= 16'h0000;
            ba_cnt_q <= 16'h0000;
        end else if (ce_i) begin
            if (go_req) begin
                pass_cnt_q <= 16'h0000;
                ram_cnt_q <= 16'h0000;
                ba_cnt_q <= 16'h0000;
            end else if (state_q == ST_RUN) begin
                if (pass_match) pass_cnt_q <= pass_cnt_q + 16'h0001;
                if (ram_match) ram_cnt_q <= ram_cnt_q + 16'h0001;
                if (ba_match) ba_cnt_q <= ba_cnt_q + 16'h0001;
            end
        end
    end

    // ********************************************************************
    // run control, pending break and capture
    // ********************************************************************
    logic defer, take;
    assign defer = ex.valid && (ex.skip_busy || ex.irq_xfer);
    // abort needs no retired instruction
    assign take = state_q == ST_RUN && !defer && (hit_src == EBC_SRC_ABORT
        || ex.valid && (pend_q || hit_src != EBC_SRC_NONE));

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_IDLE;
            run_o <= 1'b0;
            clr_exec_o <= 1'b0;
            load_pc_o <= 1'b0;
            start_pc_o <= 12'h000;
            tbc_hold_o <= 1'b1;
            ais_skip_en_o <= 1'b0;
        end else if (ce_i) begin
            clr_exec_o <= 1'b0;
            load_pc_o <= 1'b0;
            ais_skip_en_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (go_req && pwdata_i[EBC_CTRL_ADRV]) begin
                        start_pc_o <= pwdata_i[27:16];
                        load_pc_o <= 1'b1;
                        clr_exec_o <= 1'b1;
                        state_q <= ST_CLEAR;
                    end else if (go_req) begin
                        run_o <= 1'b1;
                        tbc_hold_o <= 1'b0;
                        ais_skip_en_o <= 1'b1;
                        state_q <= ST_RUN;
                    end
                end
                ST_CLEAR: begin
                    run_o <= 1'b1;
                    tbc_hold_o <= 1'b0;
                    ais_skip_en_o <= 1'b1;
                    state_q <= ST_RUN;
                end
                ST_RUN: begin
                    if (take) begin
                        run_o <= 1'b0;
                        tbc_hold_o <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_q <= 1'b0;
            pend_src_q <= EBC_SRC_NONE;
            src_q <= EBC_SRC_NONE;
            bpc_q <= 12'h000;
            npc_q <= 12'h000;
            btp_q <= 12'h000;
            duty_q <= 2'h0;
        end else if (ce_i) begin
            if (go_req) begin
                pend_q <= 1'b0;
            end else if (state_q == ST_RUN) begin
                if (defer && !pend_q && hit_src != EBC_SRC_NONE) begin
                    pend_q <= 1'b1;
                    pend_src_q <= hit_src;
                end else if (take) begin
                    pend_q <= 1'b0;
                    src_q <= pend_q ? pend_src_q : hit_src;
                    bpc_q <= ex.pc;
                    npc_q <= ex.next_pc;
                    btp_q <= trace_ptr_i;
                    if (ex.valid) duty_q <= ex.duty;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            duty_warn_o <= 1'b0;
        end else if (ce_i) begin
            duty_warn_o <= !run_o && src_q != EBC_SRC_NONE && duty_q != mask_duty_q;
        end
    end

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_break_stops_run: assert property (ce_i && take |=> !run_o && tbc_hold_o)
        else $error("run not stopped after break");
    a_clear_before_run: assert property (ce_i && clr_exec_o |=> run_o)
        else $error("clear not followed by run");
    a_defer_no_stop: assert property (ce_i && state_q == ST_RUN && defer |=> run_o)
        else $error("stopped during skip or interrupt transfer");
    a_pending_held: assert property (ce_i && state_q == ST_RUN && ex.valid && defer
        && hit_src != EBC_SRC_NONE |=> pend_q)
        else $error("break not held pending");
    a_abort_halt: assert property (ce_i && state_q == ST_RUN && ex.halt_mode && !ex.valid
        && !pend_q |=> run_o)
        else $error("abort accepted in halt mode");
    a_range_stop: assert property (ce_i && state_q == ST_RUN && ex.valid && !defer
        && ex.pc > top |=> !run_o && src_q != EBC_SRC_NONE)
        else $error("out of range not stopped");
    a_skip_no_list: assert property (ex.skipped && hit_src == EBC_SRC_LIST |-> 1'b0)
        else $error("skipped instruction raised address break");
    a_capture_pc: assert property (ce_i && take |=> bpc_q == $past(ex.pc))
        else $error("break pc not captured");
    a_ram_other_addr: assert property (ce_i && ex.ram_adr != ram_adr_q && !go_req
        |=> ram_cnt_q == $past(ram_cnt_q))
        else $error("write elsewhere counted");

    c_direct_break: cover property (ce_i && take && !pend_q);
    c_pending_break: cover property (ce_i && take && pend_q);
    c_start_addr: cover property (ce_i && clr_exec_o);
    c_duty_warn: cover property (duty_warn_o);
endmodule

// ==== tb/ebc_core_model.sv ====
// partner model of the emulated core, retiring one commanded instruction a cycle
`timescale 1ns/1ns
module ebc_core_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic clr_exec_i,
    input wire logic load_pc_i,
    input wire logic [11:0] start_pc_i,
    input wire logic halt_i,
    input wire ebc_pkg::ebc_exec_type cmd_i,
    output ebc_pkg::ebc_exec_type exec_o,
    output logic [11:0] tp_o,
    output logic [11:0] pc_o
);
    import ebc_pkg::*;
    // ************************************************************
    // retired instruction and trace state
    // ************************************************************
    // outside execution the fields churn so nothing stale looks valid
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            exec_o <= '0;
        end else if (run_i && cmd_i.valid) begin
            exec_o <= cmd_i;
        end else begin
            exec_o <= ~exec_o;
            exec_o.valid <= 1'b0;
            exec_o.halt_mode <= halt_i;
        end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tp_o <= 12'h000;
            pc_o <= 12'h000;
        end else begin
            if (clr_exec_i) begin
                tp_o <= 12'h000;
            end else if (run_i && cmd_i.valid) begin
                tp_o <= tp_o + 12'h001;
            end
            if (load_pc_i) begin
                pc_o <= start_pc_i;
            end
        end
    end
endmodule

// ==== tb/emulation_break_controller_tb.sv ====
// self-checking bench for the emulation break controller
`timescale 1ns/1ns
module emulation_break_controller_tb;
    import ebc_pkg::*;
    logic clk_i, nrst_i, ce_i, psel_i, penable_i, pwrite_i, halt, pready_o, pslverr_o;
    logic run_o, clr_exec_o, load_pc_o, tbc_hold_o, ais_skip_en_o, duty_warn_o;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, seed, r;
    logic [11:0] tp, start_pc_o, pc_m;
    logic [15:0] rt;
    logic [32:0] e;
    logic [32:0] expq[$];
    ebc_exec_type cmd, exec;
    int n_fail, checks, cyc, n_clr, n_ais, n_go, n_adr, ntp;
    ebc_break_ctrl ebc_break_ctrl_inst (.clk_i, .nrst_i, .ce_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .exec_i(exec),
        .trace_ptr_i(tp), .run_o, .clr_exec_o, .start_pc_o, .load_pc_o, .tbc_hold_o,
        .ais_skip_en_o, .duty_warn_o);
    ebc_core_model ebc_core_model_inst (.clk_i, .nrst_i, .run_i(run_o), .clr_exec_i(clr_exec_o),
        .load_pc_i(load_pc_o), .start_pc_i(start_pc_o), .halt_i(halt), .cmd_i(cmd),
        .exec_o(exec), .tp_o(tp), .pc_o(pc_m));
    // ************************************************************
    // helpers
    // ************************************************************
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // f: [0]wr8 [1]ram [2]ba [3]cc [4]tp [5]bp [6]skipped [7]skip busy [8]irq [10:9]duty
    function ebc_exec_type ins(input logic [11:0] pc, input logic [10:0] f,
        input logic [10:0] a, input logic [7:0] d);
        ebc_exec_type c;
        c = '0;
        {c.duty, c.irq_xfer, c.skip_busy, c.skipped, c.bp_bit, c.tp_ovf} = f[10:4];
        {c.cc_ovf, c.ba_wr, c.ram_wr, c.wr8} = f[3:0];
        c.valid = 1'b1;
        c.pc = pc;
        c.next_pc = pc + 12'h001;
        c.ram_adr = a;
        c.ram_dat = d;
        c.ba_dat = d;
        return c;
    endfunction
    task cmp(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, g, x);
        end
    endtask
    task chk(input logic g, input logic x);
        cmp({31'h0, g}, {31'h0, x});
    endtask
    task close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task issue(input ebc_exec_type c);
        cmd <= c;
        if (c.valid) ntp++;
        @(posedge clk_i);
    endtask
    task fill();
        r = rnd();
        issue(ins({3'h1, r[8:0]}, 11'h000, 11'h000, 8'h00));
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x, input logic err);
        expq.push_back({err, x});
        apb(1'b0, a, 32'h0);
    endtask
    task go(input logic [31:0] cond, input logic adr, input logic lg);
        apb(1'b1, EBC_COND_ADR, cond);
        n_go++;
        n_adr += adr;
        if (adr) ntp = 0;
        apb(1'b1, EBC_CTRL_ADR, {4'h0, 12'h0A5, 12'h000, lg, 1'b0, adr, 1'b1});
        for (int i = 0; i < 4 && run_o !== 1'b1; i++) @(posedge clk_i);
        chk(run_o, 1'b1);
        chk(tbc_hold_o, 1'b0);
        if (adr) cmp({20'h0, pc_m}, 32'h0A5);
    endtask
    task brk(input logic [3:0] s, input logic [11:0] pc, input logic w);
        issue('0);
        for (int i = 0; i < 8 && run_o === 1'b1; i++) @(posedge clk_i);
        chk(run_o, 1'b0);
        chk(tbc_hold_o, 1'b1);
        rd(EBC_STAT_ADR, {10'h0, w, 1'b0, s, rt}, 1'b0);
        chk(duty_warn_o, w);
        if (pc != 12'h000) begin
            rd(EBC_BPC_ADR, {4'h0, pc + 12'h001, 4'h0, pc}, 1'b0);
            rd(EBC_TP_ADR, {20'h0, ntp[11:0]}, 1'b0);
        end
        $display("test ended with source %0d", s);
    endtask
    // ************************************************************
    // clock, result watcher and timeout
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && expq.size() > 0) begin
            e = expq.pop_front();
            cmp(prdata_o, e[31:0]);
            cmp({31'h0, pslverr_o}, {31'h0, e[32]});
        end
        n_clr += (clr_exec_o === 1'b1);
        n_ais += (ais_skip_en_o === 1'b1);
        cyc++;
        if (cyc == 8000) begin
            n_fail++;
            close_out();
        end
    end
    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        nrst_i = 1'b0;
        ce_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        cmd = '0;
        halt = 1'b0;
        seed = 32'h24;
        rt = 16'h0;
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        chk(tbc_hold_o, 1'b1);
        rd(EBC_STAT_ADR, 32'h0, 1'b0);
        rd(8'h90, 32'h0, 1'b1);
        apb(1'b1, 8'h8C, 32'h8000_0100);
        go(32'h8, 1'b1, 1'b0);
        issue(ins(12'h100, 11'h040, 11'h000, 8'h00));
        fill();
        fill();
        chk(run_o, 1'b1);
        issue(ins(12'h100, 11'h000, 11'h000, 8'h00));
        brk(EBC_SRC_LIST, 12'h100, 1'b0);
        apb(1'b1, EBC_PASS_ADR, 32'h0040_0003);
        go(32'h10, 1'b0, 1'b0);
        issue(ins(12'h040, 11'h000, 11'h000, 8'h00));
        fill();
        issue(ins(12'h040, 11'h000, 11'h000, 8'h00));
        fill();
        fill();
        chk(run_o, 1'b1);
        issue(ins(12'h040, 11'h000, 11'h000, 8'h00));
        brk(EBC_SRC_PASS, 12'h040, 1'b0);
        apb(1'b1, EBC_STAT_ADR, 32'h2);
        rt = 16'h2;
        apb(1'b1, EBC_RAM_ADR, 32'h0781_0003);
        go(32'hA0, 1'b1, 1'b0);
        issue(ins(12'h050, 11'h003, 11'h781, 8'h03));
        issue(ins(12'h051, 11'h002, 11'h782, 8'h03));
        issue(ins(12'h052, 11'h002, 11'h781, 8'h03));
        fill();
        fill();
        chk(run_o, 1'b1);
        issue(ins(12'h053, 11'h002, 11'h781, 8'h03));
        brk(EBC_SRC_RAM, 12'h053, 1'b0);
        apb(1'b1, EBC_RAM_ADR, 32'h0781_00F5);
        go(32'h20, 1'b1, 1'b0);
        issue(ins(12'h060, 11'h003, 11'h781, 8'hF5));
        issue(ins(12'h061, 11'h002, 11'h781, 8'h05));
        brk(EBC_SRC_RAM, 12'h061, 1'b0);
        apb(1'b1, EBC_BA_ADR, 32'h0002_001F);
        go(32'h40, 1'b1, 1'b0);
        issue(ins(12'h070, 11'h004, 11'h000, 8'h1F));
        issue(ins(12'h071, 11'h005, 11'h000, 8'h1F));
        fill();
        fill();
        chk(run_o, 1'b1);
        issue(ins(12'h072, 11'h005, 11'h000, 8'h1F));
        brk(EBC_SRC_BA, 12'h072, 1'b0);
        apb(1'b1, EBC_BA_ADR, 32'h0001_0003);
        go(32'h140, 1'b1, 1'b0);
        issue(ins(12'h080, 11'h004, 11'h000, 8'hA3));
        brk(EBC_SRC_BA, 12'h080, 1'b0);
        for (int k = 0; k < 3; k++) begin
            go(32'h1 << k, 1'b1, 1'b0);
            issue(ins(12'h090, 11'h020 >> ((k + 1) % 3), 11'h000, 8'h00));
            fill();
            fill();
            chk(run_o, 1'b1);
            issue(ins(12'h123, {(k == 1) ? 2'h1 : 2'h0, 9'h020 >> k}, 11'h000, 8'h00));
            brk(4'(6 + k), 12'h123, k == 1);
        end
        for (int j = 0; j < 2; j++) begin
            go(32'h2, 1'b1, 1'b0);
            issue(ins(12'h300, j ? 11'h110 : 11'h090, 11'h000, 8'h00));
            issue(ins(12'h301, j ? 11'h100 : 11'h080, 11'h000, 8'h00));
            issue('0);
            issue('0);
            chk(run_o, 1'b1);
            fill();
            brk(EBC_SRC_TP, 12'h000, 1'b0);
        end
        go(32'h0, 1'b1, 1'b0);
        issue(ins(12'h7DF, 11'h000, 11'h000, 8'h00));
        issue(ins(12'h7E0, 11'h000, 11'h000, 8'h00));
        brk(EBC_SRC_RANGE, 12'h7E0, 1'b0);
        go(32'h0, 1'b1, 1'b1);
        issue(ins(12'h7E0, 11'h000, 11'h000, 8'h00));
        issue(ins(12'hFDF, 11'h000, 11'h000, 8'h00));
        issue(ins(12'hFE0, 11'h000, 11'h000, 8'h00));
        brk(EBC_SRC_RANGE, 12'hFE0, 1'b0);
        go(32'h0, 1'b0, 1'b0);
        halt <= 1'b1;
        apb(1'b1, EBC_CTRL_ADR, 32'h4);
        repeat (6) @(posedge clk_i);
        chk(run_o, 1'b1);
        halt <= 1'b0;
        brk(EBC_SRC_ABORT, 12'h000, 1'b0);
        apb(1'b1, EBC_CTRL_ADR, 32'h0);
        cmp(n_clr, n_adr);
        cmp(n_ais, n_go);
        cmp(expq.size(), 32'h0);
        close_out();
    end
endmodule
